// >>> shared/cas_pkg.sv
// constants and carrier types for the charger alert and status registers
//
// Overview of operation
// - entering equalize, absorb, suspend, precharge, main charge sets 10..6
// - pause, terminations, time, missing and short faults set alerts 5..0
// - a state alert bit sets only while its enable bit is on
// - a loop alert bit sets only while its enable bit is on
// - loop becoming active sets loop alerts 3..0
// - host writing zero to an alert bit clears it
// - a set alert stays high until cleared or its enable drops
// - ratio above cold threshold sets limit bit 1, below hot sets bit 0
// - system status word is read-only and tracks conditions live
// - status bit 13 shows the charger is operating
// - status bit 11 shows tracking pin selects power point tracking
// - rising edge on equalize pin sets bit 10 and queues equalization
// - status bit 9 shows gate-driver supply above its lockout level
// - status bit 8 flags an invalid series-count strap
// - status bit 6 only when every charging condition is met
// - status bit 5 flags a missing timing resistor
// - status bit 4 flags die above thermal shutdown level
// - limit alerts sit in their own register, gated by own enables
// - charger state bits are mutually exclusive, one at most
package cas_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] COLD_THR_ADDR = 8'h0B;
  localparam logic [7:0] HOT_THR_ADDR = 8'h0C;
  localparam logic [7:0] LIM_EN_ADDR = 8'h0D;
  localparam logic [7:0] ST_EN_ADDR = 8'h0E;
  localparam logic [7:0] LOOP_EN_ADDR = 8'h0F;
  localparam logic [7:0] STATE_ADDR = 8'h34;
  localparam logic [7:0] LOOP_ADDR = 8'h35;
  localparam logic [7:0] LIM_ALERT_ADDR = 8'h36;
  localparam logic [7:0] ST_ALERT_ADDR = 8'h37;
  localparam logic [7:0] LOOP_ALERT_ADDR = 8'h38;
  localparam logic [7:0] SYS_ADDR = 8'h39;

  // ----------------------------------------------------------------
  // field widths, positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_W = 11;
  localparam int LOOP_W = 4;
  localparam int LIM_W = 2;
  localparam int LIM_COLD = 1;
  localparam int LIM_HOT = 0;
  localparam int ST_EQUALIZE = 10;
  localparam int SYS_CHG_ON = 13;
  localparam int SYS_MPPT = 11;
  localparam int SYS_EQUALIZE_REQ = 10;
  localparam int SYS_DRV_OK = 9;
  localparam int SYS_CELL_ERR = 8;
  localparam int SYS_OK_CHG = 6;
  localparam int SYS_NO_RES = 5;
  localparam int SYS_TSD = 4;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [15:0] wdata;
  } cas_reg_req_t;

  typedef struct packed {
    logic chargerActive;
    logic mpptSelect;
    logic equalizationRequestPin;
    logic drvSupplyGood;
    logic timingResistorAbsentFlag;
    logic thermalShutdown;
    logic inputSupplyOk;
  } cas_sys_in_t;

endpackage

// >>> design/cas_regs.sv
// alert, enable, threshold and live status registers of the charger
`timescale 1ns/1ps
module cas_regs #(
  parameter int CELL_W = 2,
  parameter int MAX_SERIES = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access from the serial port
  input wire cas_pkg::cas_reg_req_t regReq,
  output logic [15:0] regRdata,
  // charger core indications
  input wire logic [cas_pkg::ST_W-1:0] chargerState,
  input wire logic [cas_pkg::LOOP_W-1:0] loopStatus,
  input wire logic [15:0] ntcRatio,
  // pins and comparators
  input wire cas_pkg::cas_sys_in_t sysIn,
  input wire logic [CELL_W-1:0] seriesCountPins,
  // live status word
  output logic [15:0] systemFlags
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (CELL_W < 1 || CELL_W > 8 || MAX_SERIES < 1 ||
      MAX_SERIES >= (1 << CELL_W))
  begin : g_bad_param
    $error("cas_regs: MAX_SERIES does not fit CELL_W");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] coldThreshold_reg, coldThreshold_next;
  logic [15:0] hotThreshold_reg, hotThreshold_next;
  logic [cas_pkg::LIM_W-1:0] limEn_reg, limEn_next;
  logic [cas_pkg::ST_W-1:0] stEn_reg, stEn_next;
  logic [cas_pkg::LOOP_W-1:0] loopEn_reg, loopEn_next;
  logic [cas_pkg::ST_W-1:0] stAlert_reg, stAlert_next;
  logic [cas_pkg::LOOP_W-1:0] loopAlert_reg, loopAlert_next;
  logic [cas_pkg::LIM_W-1:0] limAlert_reg, limAlert_next;
  logic [cas_pkg::ST_W-1:0] state_reg, state_next;
  logic [cas_pkg::LOOP_W-1:0] loop_reg, loop_next;
  logic [cas_pkg::LIM_W-1:0] limPrev_reg, limPrev_next;
  logic pinPrev_reg, pinPrev_next;
  logic equalizeReq_reg, equalizeReq_next;
  logic [15:0] sys_reg, sys_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [cas_pkg::ST_W-1:0] stOne, stRise, stSet;
  logic [cas_pkg::LOOP_W-1:0] loopOne, loopRise, loopSet;
  logic [cas_pkg::LIM_W-1:0] limCond, limSet;
  logic wrSt, wrLoop, wrLim, wrStEn, wrLoopEn, wrLimEn;
  logic equalizeRise, cellCountError, chargePermittedFlag;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wrSt = regReq.wr && regReq.addr == cas_pkg::ST_ALERT_ADDR;
  assign wrLoop = regReq.wr && regReq.addr == cas_pkg::LOOP_ALERT_ADDR;
  assign wrLim = regReq.wr && regReq.addr == cas_pkg::LIM_ALERT_ADDR;
  assign wrStEn = regReq.wr && regReq.addr == cas_pkg::ST_EN_ADDR;
  assign wrLoopEn = regReq.wr && regReq.addr == cas_pkg::LOOP_EN_ADDR;
  assign wrLimEn = regReq.wr && regReq.addr == cas_pkg::LIM_EN_ADDR;

  // ----------------------------------------------------------------
  // source indications and edges
  // ----------------------------------------------------------------
  // keep only the lowest asserted state so software never sees two
  assign stOne = chargerState & (~chargerState + 1'b1);
  assign loopOne = loopStatus & (~loopStatus + 1'b1);
  // rising edges against the registered copy, so a level that stays
  // asserted after a clear does not set the alert again
  assign stRise = stOne & ~state_reg;
  assign loopRise = loopOne & ~loop_reg;
  // cold means ratio above its limit, hot means ratio below its limit
  assign limCond[cas_pkg::LIM_COLD] =
    $signed(ntcRatio) > $signed(coldThreshold_reg);
  assign limCond[cas_pkg::LIM_HOT] =
    $signed(ntcRatio) < $signed(hotThreshold_reg);
  assign stSet = stRise & stEn_next;
  assign loopSet = loopRise & loopEn_next;
  assign limSet = limCond & ~limPrev_reg & limEn_next;
  assign equalizeRise = sysIn.equalizationRequestPin & ~pinPrev_reg;

  // ----------------------------------------------------------------
  // configuration registers: next values
  // ----------------------------------------------------------------
  always_comb
  begin
    coldThreshold_next = coldThreshold_reg;
    hotThreshold_next = hotThreshold_reg;
    limEn_next = limEn_reg;
    stEn_next = stEn_reg;
    loopEn_next = loopEn_reg;
    if (regReq.wr && regReq.addr == cas_pkg::COLD_THR_ADDR)
      coldThreshold_next = regReq.wdata;
    if (regReq.wr && regReq.addr == cas_pkg::HOT_THR_ADDR)
      hotThreshold_next = regReq.wdata;
    if (wrLimEn)
      limEn_next = regReq.wdata[cas_pkg::LIM_W-1:0];
    if (wrStEn)
      stEn_next = regReq.wdata[cas_pkg::ST_W-1:0];
    if (wrLoopEn)
      loopEn_next = regReq.wdata[cas_pkg::LOOP_W-1:0];
  end

  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      coldThreshold_reg <= cas_pkg::WORD_RST;
      hotThreshold_reg <= cas_pkg::WORD_RST;
      limEn_reg <= '0;
      stEn_reg <= '0;
      loopEn_reg <= '0;
    end
    else
    begin
      coldThreshold_reg <= coldThreshold_next;
      hotThreshold_reg <= hotThreshold_next;
      limEn_reg <= limEn_next;
      stEn_reg <= stEn_next;
      loopEn_reg <= loopEn_next;
    end
  end

  // ----------------------------------------------------------------
  // sticky alerts: next values
  // ----------------------------------------------------------------
  // a write keeps ones and clears zeros; a set in the same cycle wins;
  // dropping the enable removes the bit at once
  always_comb
  begin
    stAlert_next = stAlert_reg;
    loopAlert_next = loopAlert_reg;
    limAlert_next = limAlert_reg;
    if (wrSt)
      stAlert_next = stAlert_reg & regReq.wdata[cas_pkg::ST_W-1:0];
    if (wrLoop)
      loopAlert_next =
        loopAlert_reg & regReq.wdata[cas_pkg::LOOP_W-1:0];
    if (wrLim)
      limAlert_next =
        limAlert_reg & regReq.wdata[cas_pkg::LIM_W-1:0];
    stAlert_next = (stAlert_next | stSet) & stEn_next;
    loopAlert_next = (loopAlert_next | loopSet) & loopEn_next;
    limAlert_next = (limAlert_next | limSet) & limEn_next;
  end

  // sticky alerts
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stAlert_reg <= '0;
      loopAlert_reg <= '0;
      limAlert_reg <= '0;
    end
    else
    begin
      stAlert_reg <= stAlert_next;
      loopAlert_reg <= loopAlert_next;
      limAlert_reg <= limAlert_next;
    end
  end

  // ----------------------------------------------------------------
  // live status: next values
  // ----------------------------------------------------------------
  assign cellCountError = seriesCountPins == '0 ||
    seriesCountPins > CELL_W'(MAX_SERIES);
  // every lockout must be clear before charging is allowed
  assign chargePermittedFlag = sysIn.drvSupplyGood && !cellCountError &&
    !sysIn.timingResistorAbsentFlag && !sysIn.thermalShutdown &&
    sysIn.inputSupplyOk;

  always_comb
  begin
    state_next = stOne;
    loop_next = loopOne;
    limPrev_next = limCond;
    pinPrev_next = sysIn.equalizationRequestPin;
    // queued request is consumed once equalization is entered
    equalizeReq_next = equalizeReq_reg;
    if (state_reg[cas_pkg::ST_EQUALIZE])
      equalizeReq_next = 1'b0;
    if (equalizeRise)
      equalizeReq_next = 1'b1;
    sys_next = '0;
    sys_next[cas_pkg::SYS_CHG_ON] = sysIn.chargerActive;
    sys_next[cas_pkg::SYS_MPPT] = sysIn.mpptSelect;
    sys_next[cas_pkg::SYS_EQUALIZE_REQ] = equalizeReq_next;
    sys_next[cas_pkg::SYS_DRV_OK] = sysIn.drvSupplyGood;
    sys_next[cas_pkg::SYS_CELL_ERR] = cellCountError;
    sys_next[cas_pkg::SYS_OK_CHG] = chargePermittedFlag;
    sys_next[cas_pkg::SYS_NO_RES] =
      sysIn.timingResistorAbsentFlag;
    sys_next[cas_pkg::SYS_TSD] = sysIn.thermalShutdown;
  end

  // live status, refreshed every cycle; only the queued equalize request is held
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= '0;
      loop_reg <= '0;
      limPrev_reg <= '0;
      pinPrev_reg <= 1'b0;
      equalizeReq_reg <= 1'b0;
      sys_reg <= cas_pkg::WORD_RST;
    end
    else
    begin
      state_reg <= state_next;
      loop_reg <= loop_next;
      limPrev_reg <= limPrev_next;
      pinPrev_reg <= pinPrev_next;
      equalizeReq_reg <= equalizeReq_next;
      sys_reg <= sys_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // status word has no write path, so writes to it are dropped
  always_comb
  begin
    rdata_next = '0;
    if (regReq.addr == cas_pkg::COLD_THR_ADDR)
      rdata_next = coldThreshold_reg;
    else if (regReq.addr == cas_pkg::HOT_THR_ADDR)
      rdata_next = hotThreshold_reg;
    else if (regReq.addr == cas_pkg::LIM_EN_ADDR)
      rdata_next[cas_pkg::LIM_W-1:0] = limEn_reg;
    else if (regReq.addr == cas_pkg::ST_EN_ADDR)
      rdata_next[cas_pkg::ST_W-1:0] = stEn_reg;
    else if (regReq.addr == cas_pkg::LOOP_EN_ADDR)
      rdata_next[cas_pkg::LOOP_W-1:0] = loopEn_reg;
    else if (regReq.addr == cas_pkg::STATE_ADDR)
      rdata_next[cas_pkg::ST_W-1:0] = state_reg;
    else if (regReq.addr == cas_pkg::LOOP_ADDR)
      rdata_next[cas_pkg::LOOP_W-1:0] = loop_reg;
    else if (regReq.addr == cas_pkg::LIM_ALERT_ADDR)
      rdata_next[cas_pkg::LIM_W-1:0] = limAlert_reg;
    else if (regReq.addr == cas_pkg::ST_ALERT_ADDR)
      rdata_next[cas_pkg::ST_W-1:0] = stAlert_reg;
    else if (regReq.addr == cas_pkg::LOOP_ALERT_ADDR)
      rdata_next[cas_pkg::LOOP_W-1:0] = loopAlert_reg;
    else if (regReq.addr == cas_pkg::SYS_ADDR)
      rdata_next = sys_reg;
  end

  // read data
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_reg <= cas_pkg::WORD_RST;
    else
      rdata_reg <= rdata_next;
  end

  assign regRdata = rdata_reg;
  assign systemFlags = sys_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_state_set: assert property (
    ($past(stSet) & ~stAlert_reg) == '0)
    else $error("enabled state entry did not set its alert");
  a_loop_set: assert property (
    |loopSet |=> (loopAlert_reg & $past(loopSet)) == $past(loopSet))
    else $error("loop activation did not set its alert");
  a_state_gate: assert property (
    (stAlert_reg & ~stEn_reg) == '0)
    else $error("state alert high with enable off");
  a_loop_gate: assert property (
    (loopAlert_reg & ~loopEn_reg) == '0)
    else $error("loop alert high with enable off");
  a_clear_write: assert property (
    wrSt && !regReq.wdata[0] && !stSet[0] |=> !stAlert_reg[0])
    else $error("writing zero did not clear alert");
  a_hold_alert: assert property (
    stAlert_reg[0] && !wrSt && !wrStEn |=> stAlert_reg[0])
    else $error("alert dropped without clear or disable");
  a_limit_set: assert property (
    limSet[cas_pkg::LIM_COLD] |=> limAlert_reg[cas_pkg::LIM_COLD])
    else $error("cold crossing did not set alert");
  a_status_track: assert property (
    sysIn.chargerActive |=> sys_reg[cas_pkg::SYS_CHG_ON] ##1
    sys_reg[cas_pkg::SYS_CHG_ON] == $past(sysIn.chargerActive))
    else $error("status word not following live condition");
  a_equalize_req: assert property (
    equalizeRise |=> equalizeReq_reg && sys_reg[cas_pkg::SYS_EQUALIZE_REQ])
    else $error("equalize edge not queued");
  a_ok_flag: assert property (
    sys_reg[cas_pkg::SYS_OK_CHG] |-> sys_reg[cas_pkg::SYS_DRV_OK] &&
    !sys_reg[cas_pkg::SYS_CELL_ERR] && !sys_reg[cas_pkg::SYS_TSD] &&
    !sys_reg[cas_pkg::SYS_NO_RES])
    else $error("charge permitted despite lockout");
  a_onehot_state: assert property (
    $onehot0(state_reg))
    else $error("more than one charger state shown");
  a_no_retrigger: assert property (
    !stAlert_reg[0] && state_reg[0] && stOne[0] |=> !stAlert_reg[0])
    else $error("held state set its alert again");
  a_reset_clear: assert property (
    @(posedge mclk) disable iff (1'b0) $past(rst) |->
    stAlert_reg == '0 && loopAlert_reg == '0 && limAlert_reg == '0)
    else $error("alerts not clear after reset");

endmodule

// >>> sim/cas_host_model.sv
// host-side register access model for the charger alert block
`timescale 1ns/1ps
module cas_host_model (
  // clock
  input wire logic mclk,
  // register port
  output cas_pkg::cas_reg_req_t regReq,
  input wire logic [15:0] regRdata
);
  // idle request at time zero so the port never floats
  initial regReq = '0;

  // -----------------------------------------------------------------
  // access tasks
  // -----------------------------------------------------------------
  // one-cycle strobe; released data shows its inverse, not stale value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    regReq <= '{addr: a, wr: 1'b1, wdata: d};
    @(negedge mclk);
    regReq.wr <= 1'b0;
    regReq.wdata <= ~d;
  endtask

  // address held until the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    regReq.addr <= a;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    d = regRdata;
  endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the charger alert and status registers
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic mclk;
  logic rst;
  logic [cas_pkg::ST_W-1:0] chargerState;
  logic [cas_pkg::LOOP_W-1:0] loopStatus;
  logic [15:0] ntcRatio;
  logic [15:0] regRdata;
  logic [15:0] systemFlags;
  logic [1:0] seriesCountPins;
  cas_pkg::cas_reg_req_t regReq;
  cas_pkg::cas_sys_in_t sysIn;
  int miscompares = 0;
  int numChecks = 0;
  int cycles = 0;
  // status cases: pin pattern, strap code, expected word
  logic [6:0] sysCase [7] = '{7'h69, 7'h0D, 7'h0B, 7'h09, 7'h09, 7'h08,
    7'h01};
  logic [1:0] pinCase [7] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1};
  logic [15:0] expCase [7] = '{16'h2A40, 16'h0220, 16'h0210, 16'h0300,
    16'h0240, 16'h0200, 16'h0000};

  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  cas_regs #(.CELL_W(2), .MAX_SERIES(3)) i_cas_regs (
    .mclk(mclk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .chargerState(chargerState), .loopStatus(loopStatus),
    .ntcRatio(ntcRatio), .sysIn(sysIn),
    .seriesCountPins(seriesCountPins), .systemFlags(systemFlags));

  cas_host_model i_cas_host_model (
    .mclk(mclk), .regReq(regReq), .regRdata(regRdata));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_cas_host_model.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one-cycle source pulses give a clean rise and fall
  task automatic pulseSt(input logic [cas_pkg::ST_W-1:0] v);
    @(negedge mclk) chargerState = v;
    @(negedge mclk) chargerState = '0;
  endtask

  task automatic pulseLp(input logic [cas_pkg::LOOP_W-1:0] v);
    @(negedge mclk) loopStatus = v;
    @(negedge mclk) loopStatus = '0;
  endtask

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      close_out();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    chargerState = '0;
    loopStatus = '0;
    ntcRatio = 16'h0800;
    sysIn = '0;
    seriesCountPins = 2'h1;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    rc(cas_pkg::ST_ALERT_ADDR, 16'h0000);
    rc(cas_pkg::LOOP_ALERT_ADDR, 16'h0000);
    rc(cas_pkg::LIM_ALERT_ADDR, 16'h0000);
    rc(8'h50, 16'h0000);
    $display("test reset done");
    // every state entry, state register one-hot
    i_cas_host_model.wr(cas_pkg::ST_EN_ADDR, 16'h07FF);
    for (int b = 0; b < cas_pkg::ST_W; b++)
    begin
      @(negedge mclk) chargerState = 11'(1 << b);
      rc(cas_pkg::STATE_ADDR, 16'(1 << b));
      chargerState = '0;
    end
    rc(cas_pkg::ST_ALERT_ADDR, 16'h07FF);
    i_cas_host_model.wr(cas_pkg::ST_ALERT_ADDR, 16'hFFFE);
    rc(cas_pkg::ST_ALERT_ADDR, 16'h07FE);
    // source held high must not re-arm after a clear
    @(negedge mclk) chargerState = 11'h001;
    rc(cas_pkg::ST_ALERT_ADDR, 16'h07FF);
    i_cas_host_model.wr(cas_pkg::ST_ALERT_ADDR, 16'h0000);
    rc(cas_pkg::ST_ALERT_ADDR, 16'h0000);
    @(negedge mclk) chargerState = 11'h0C0;
    rc(cas_pkg::STATE_ADDR, 16'h0040);
    chargerState = '0;
    // a second alert that must survive the other bit's disable
    pulseSt(11'h080);
    i_cas_host_model.wr(cas_pkg::ST_EN_ADDR, 16'h07BF);
    rc(cas_pkg::ST_EN_ADDR, 16'h07BF);
    rc(cas_pkg::ST_ALERT_ADDR, 16'h0080);
    pulseSt(11'h040);
    rc(cas_pkg::ST_ALERT_ADDR, 16'h0080);
    $display("test state alerts done");
    i_cas_host_model.wr(cas_pkg::LOOP_EN_ADDR, 16'h0005);
    // loop indications are exclusive, so each is raised on its own
    for (int b = 0; b < cas_pkg::LOOP_W; b++)
    begin
      pulseLp(4'(1 << b));
    end
    rc(cas_pkg::LOOP_ALERT_ADDR, 16'h0005);
    i_cas_host_model.wr(cas_pkg::LOOP_EN_ADDR, 16'h000F);
    for (int b = 0; b < cas_pkg::LOOP_W; b++)
    begin
      pulseLp(4'(1 << b));
    end
    rc(cas_pkg::LOOP_ALERT_ADDR, 16'h000F);
    $display("test loop alerts done");
    i_cas_host_model.wr(cas_pkg::COLD_THR_ADDR, 16'h1000);
    i_cas_host_model.wr(cas_pkg::HOT_THR_ADDR, 16'h0100);
    i_cas_host_model.wr(cas_pkg::LIM_EN_ADDR, 16'h0003);
    rc(cas_pkg::COLD_THR_ADDR, 16'h1000);
    rc(cas_pkg::LIM_ALERT_ADDR, 16'h0000);
    @(negedge mclk) ntcRatio = 16'h2000;
    rc(cas_pkg::LIM_ALERT_ADDR, 16'h0002);
    @(negedge mclk) ntcRatio = 16'h0010;
    rc(cas_pkg::LIM_ALERT_ADDR, 16'h0003);
    i_cas_host_model.wr(cas_pkg::LIM_EN_ADDR, 16'h0001);
    rc(cas_pkg::LIM_ALERT_ADDR, 16'h0001);
    $display("test limit alerts done");
    // live status word follows every case, one cycle behind
    for (int i = 0; i < 7; i++)
    begin
      @(negedge mclk) sysIn = sysCase[i];
      seriesCountPins = pinCase[i];
      tick(2);
      `CHK(systemFlags, expCase[i])
    end
    i_cas_host_model.wr(cas_pkg::SYS_ADDR, 16'hFFFF);
    rc(cas_pkg::SYS_ADDR, 16'h0000);
    @(negedge mclk) sysIn.equalizationRequestPin = 1'b1;
    tick(2);
    `CHK(systemFlags[cas_pkg::SYS_EQUALIZE_REQ], 1'b1)
    sysIn.equalizationRequestPin = 1'b0;
    tick(2);
    `CHK(systemFlags[cas_pkg::SYS_EQUALIZE_REQ], 1'b1)
    pulseSt(11'h400);
    tick(2);
    `CHK(systemFlags[cas_pkg::SYS_EQUALIZE_REQ], 1'b0)
    $display("test system status done");
    close_out();
  end
endmodule
